//--- logic/flash_seq_pkg.sv
// Package: frame bytes, status codes, command codes and carrier types of the sequencer
package flash_seq_pkg;
  // Frame delimiters and the link filler byte
  localparam logic [7:0] FRAME_SOH    = 8'h01;
  localparam logic [7:0] FRAME_STX    = 8'h02;
  localparam logic [7:0] FRAME_ETX    = 8'h03;
  localparam logic [7:0] IDLE_BYTE    = 8'hff;
  // Status codes reported in the first status byte
  localparam logic [7:0] ST_CMD_ERR   = 8'h04;
  localparam logic [7:0] ST_PARAM_ERR = 8'h05;
  localparam logic [7:0] ST_ACK       = 8'h06;
  localparam logic [7:0] ST_SUM_ERR   = 8'h07;
  localparam logic [7:0] ST_PROTECT   = 8'h10;
  localparam logic [7:0] ST_NACK      = 8'h15;
  localparam logic [7:0] ST_MARGIN    = 8'h1a;
  localparam logic [7:0] ST_BUSY      = 8'hff;  // Busy code value is arbitrary
  // Command codes; values are arbitrary
  localparam logic [7:0] CMD_STATUS   = 8'h70;
  localparam logic [7:0] CMD_OSC_SET  = 8'h90;
  localparam logic [7:0] CMD_CHIP_ERS = 8'h20;
  localparam logic [7:0] CMD_BLK_ERS  = 8'h22;
  // Frame length field of each command and of the status reply
  localparam logic [7:0] LEN_STATUS   = 8'h01;
  localparam logic [7:0] LEN_OSC_SET  = 8'h05;
  localparam logic [7:0] LEN_CHIP_ERS = 8'h01;
  localparam logic [7:0] LEN_BLK_ERS  = 8'h07;
  localparam logic [7:0] LEN_REPLY    = 8'h01;
  // Reset values
  localparam logic [7:0] ST1_RESET    = 8'h06;
  localparam logic [31:0] FREQ_RESET  = 32'h0000_0000;

  // Erase job handed to the flash array controller
  typedef struct packed {
    logic        block;       // 1: block range, 0: whole chip
    logic [23:0] start_addr;
    logic [23:0] end_addr;
  } erase_req_type;

  typedef enum logic [2:0] {RX_HUNT, RX_LEN, RX_BODY, RX_SUM, RX_ETX} rx_state_type;
endpackage

//--- logic/flash_erase_clock_set_sequencer.sv
// Device-side interpreter for clock set, chip erase and block erase frames
`timescale 1ns/1ps
module flash_erase_clock_set_sequencer #(
  parameter int BODY_BYTES = 7
) (
  input  wire logic                          mclk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          link_sck_i,
  input  wire logic                          link_sdi_i,
  output logic                               link_sdo_o,
  input  wire logic                          chip_erase_lock_i,
  input  wire logic                          boot_rewrite_lock_i,
  input  wire logic                          block_erase_lock_i,
  output flash_seq_pkg::erase_req_type       erase_req_o,
  output logic                               erase_start_o,
  input  wire logic                          erase_done_i,
  input  wire logic                          erase_fail_i,
  output logic [31:0]                        frequency_data_o,
  output logic                               frequency_set_o,
  output logic [7:0]                         first_status_byte_o
);
  import flash_seq_pkg::*;
  localparam int IW = $clog2(BODY_BYTES);
  // Refuse a body store shorter than the longest command or wider than a length byte
  if (BODY_BYTES < 7 || BODY_BYTES > 255) begin : g_chk
    $error("BODY_BYTES must lie between 7 and 255");
  end
  // Checksum: two's complement of the byte sum of length and body
  function automatic logic [7:0] frame_sum(input logic [7:0] len,
                                           input logic [BODY_BYTES-1:0][7:0] body);
    logic [7:0] s;
    s = len;
    for (int i = 0; i < BODY_BYTES; i++) begin
      if (i < int'(len)) begin
        s = 8'(s + body[i]);
      end
    end
    return 8'(8'h00 - s);
  endfunction
  // Link pin synchronisers; only the second stage and later are read
  logic sck_s1, sck_s2, sck_s3, sdi_s1, sdi_s2;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sck_s1 <= link_sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= link_sdi_i;
      sdi_s2 <= sdi_s1;
    end
  end
  logic sck_rise;
  assign sck_rise = sck_s2 & ~sck_s3;
  // Control state
  rx_state_type                  rx_state, next_rx_state;
  logic [2:0]                    bit_cnt, next_bit_cnt;
  logic [7:0]                    rx_sh, next_rx_sh;
  logic [7:0]                    len, next_len;
  logic [7:0]                    idx, next_idx;
  logic [7:0]                    rx_sum, next_rx_sum;
  logic [BODY_BYTES-1:0][7:0]    body, next_body;
  logic [7:0]                    st1, next_st1;
  logic                          busy, next_busy;
  logic [7:0]                    tx_sh, next_tx_sh;
  logic [4:0][7:0]               tx_frame, next_tx_frame;
  logic [2:0]                    tx_pos, next_tx_pos;
  logic                          tx_active, next_tx_active;
  erase_req_type                 req, next_req;
  logic                          start, next_start;
  logic [31:0]                   freq, next_freq;
  logic                          fset, next_fset;
  // Decode strobes, also watched by the checks below
  logic                          byte_done, frame_end, etx_ok, sum_ok, len_bad;
  logic [7:0]                    byte_in, cmd;

  assign byte_in = {rx_sh[6:0], sdi_s2};
  assign cmd     = body[0];
  // Next-state logic: bit shifting, frame parsing, command decode, status
  always_comb begin
    next_rx_state  = rx_state;
    next_bit_cnt   = bit_cnt;
    next_rx_sh     = rx_sh;
    next_len       = len;
    next_idx       = idx;
    next_rx_sum    = rx_sum;
    next_body      = body;
    next_st1       = st1;
    next_busy      = busy;
    next_tx_sh     = tx_sh;
    next_tx_frame  = tx_frame;
    next_tx_pos    = tx_pos;
    next_tx_active = tx_active;
    next_req       = req;
    next_start     = 1'b0;
    next_freq      = freq;
    next_fset      = 1'b0;
    byte_done      = sck_rise && (bit_cnt == 3'd7);
    frame_end      = 1'b0;
    len_bad        = 1'b0;
    etx_ok         = (byte_in == FRAME_ETX);
    sum_ok         = (frame_sum(len, body) == rx_sum);
    // Array controller finished: a failed margin check reports its own code
    if (busy && erase_done_i) begin
      next_busy = 1'b0;
      next_st1  = erase_fail_i ? ST_MARGIN : ST_ACK;
    end

    if (sck_rise) begin
      next_bit_cnt = 3'(bit_cnt + 3'd1);
      next_rx_sh   = byte_in;
      next_tx_sh   = {tx_sh[6:0], 1'b1};
    end
    if (byte_done) begin
      // Reply bytes go out one per link byte; filler while nothing is queued
      next_tx_sh = tx_active ? tx_frame[tx_pos] : IDLE_BYTE;
      if (tx_active) begin
        next_tx_pos    = 3'(tx_pos + 3'd1);
        next_tx_active = (tx_pos != 3'd4);
      end
      unique case (rx_state)
        RX_HUNT: begin
          // Filler clocked during replies never looks like a frame start
          if (byte_in == FRAME_SOH) begin
            next_rx_state = RX_LEN;
          end
        end
        RX_LEN: begin
          if (byte_in == 8'h00 || byte_in > 8'(BODY_BYTES)) begin
            len_bad       = 1'b1;
            next_st1      = ST_NACK;
            next_rx_state = RX_HUNT;
          end else begin
            next_len      = byte_in;
            next_idx      = 8'h00;
            next_body     = '0;
            next_rx_state = RX_BODY;
          end
        end
        RX_BODY: begin
          next_body[idx[IW-1:0]] = byte_in;
          next_idx               = 8'(idx + 8'h01);
          if (idx == 8'(len - 8'h01)) begin
            next_rx_state = RX_SUM;
          end
        end
        RX_SUM: begin
          next_rx_sum   = byte_in;
          next_rx_state = RX_ETX;
        end
        RX_ETX: begin
          frame_end     = 1'b1;
          next_rx_state = RX_HUNT;
          if (!etx_ok) begin
            next_st1 = ST_NACK;
          end else if (!sum_ok) begin
            next_st1 = ST_SUM_ERR;
          end else if (cmd == CMD_STATUS && len == LEN_STATUS) begin
            // Snapshot the status; a result landing in this same cycle is not yet in st1 and misses this reply
            next_tx_frame  = {FRAME_ETX, frame_sum(LEN_REPLY, (BODY_BYTES*8)'(st1)),
                              st1, LEN_REPLY, FRAME_STX};
            next_tx_pos    = 3'd0;
            next_tx_active = 1'b1;
          end else if (busy) begin
            next_st1 = ST_NACK;
          end else if (cmd == CMD_OSC_SET) begin
            if (len != LEN_OSC_SET) begin
              next_st1 = ST_NACK;
            end else begin
              next_freq = {body[1], body[2], body[3], body[4]};
              next_fset = 1'b1;
              next_st1  = ST_ACK;
            end
          end else if (cmd == CMD_CHIP_ERS) begin
            if (len != LEN_CHIP_ERS) begin
              next_st1 = ST_NACK;
            end else if (chip_erase_lock_i || boot_rewrite_lock_i) begin
              next_st1 = ST_PROTECT;
            end else begin
              next_req   = '{block: 1'b0, start_addr: 24'h000000, end_addr: 24'hffffff};
              next_start = 1'b1;
              next_busy  = 1'b1;
              next_st1   = ST_BUSY;
            end
          end else if (cmd == CMD_BLK_ERS) begin
            if (len != LEN_BLK_ERS) begin
              next_st1 = ST_NACK;
            end else if (block_erase_lock_i) begin
              next_st1 = ST_PROTECT;
            end else if ({body[1], body[2], body[3]} > {body[4], body[5], body[6]}) begin
              next_st1 = ST_PARAM_ERR;  // Reversed range cannot be erased
            end else begin
              next_req   = '{block: 1'b1, start_addr: {body[1], body[2], body[3]},
                             end_addr: {body[4], body[5], body[6]}};
              next_start = 1'b1;
              next_busy  = 1'b1;
              next_st1   = ST_BUSY;
            end
          end else begin
            next_st1 = ST_CMD_ERR;
          end
        end
        default: next_rx_state = RX_HUNT;
      endcase
    end
  end
  // State registers
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state  <= RX_HUNT;
      bit_cnt   <= 3'd0;
      rx_sh     <= 8'h00;
      len       <= 8'h00;
      idx       <= 8'h00;
      rx_sum    <= 8'h00;
      body      <= '0;
      st1       <= ST1_RESET;
      busy      <= 1'b0;
      tx_sh     <= IDLE_BYTE;
      tx_frame  <= '0;
      tx_pos    <= 3'd0;
      tx_active <= 1'b0;
      req       <= '0;
      start     <= 1'b0;
      freq      <= FREQ_RESET;
      fset      <= 1'b0;
    end else begin
      rx_state  <= next_rx_state;
      bit_cnt   <= next_bit_cnt;
      rx_sh     <= next_rx_sh;
      len       <= next_len;
      idx       <= next_idx;
      rx_sum    <= next_rx_sum;
      body      <= next_body;
      st1       <= next_st1;
      busy      <= next_busy;
      tx_sh     <= next_tx_sh;
      tx_frame  <= next_tx_frame;
      tx_pos    <= next_tx_pos;
      tx_active <= next_tx_active;
      req       <= next_req;
      start     <= next_start;
      freq      <= next_freq;
      fset      <= next_fset;
    end
  end
  // Outputs straight from registers
  assign link_sdo_o          = tx_sh[7];
  assign erase_req_o         = req;
  assign erase_start_o       = start;
  assign frequency_data_o    = freq;
  assign frequency_set_o     = fset;
  assign first_status_byte_o = st1;
  // Checks on the reported status codes
  a_nack_bad_etx: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    frame_end && !etx_ok |=> st1 == ST_NACK && !erase_start_o)
    else $error("missing end byte not answered with negative acknowledge");
  a_nack_bad_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    byte_done && len_bad |=> st1 == ST_NACK ##1 rx_state == RX_HUNT)
    else $error("bad length field not answered with negative acknowledge");
  a_chip_protect: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    frame_end && etx_ok && sum_ok && !busy && cmd == CMD_CHIP_ERS && len == LEN_CHIP_ERS
    && (chip_erase_lock_i || boot_rewrite_lock_i) |=> st1 == ST_PROTECT && !erase_start_o)
    else $error("locked chip erase not refused with protect code");
  a_block_protect: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    frame_end && etx_ok && sum_ok && !busy && cmd == CMD_BLK_ERS && len == LEN_BLK_ERS
    && block_erase_lock_i |=> st1 == ST_PROTECT && !busy)
    else $error("locked block erase not refused with protect code");
  a_margin_fail: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    busy && req.block && erase_done_i && erase_fail_i |=> st1 == ST_MARGIN && !busy)
    else $error("failed block erase not reported with margin code");
endmodule

//--- tb/prog_model.sv
// Programmer model: drives the serial link and polls status frames
`timescale 1ns/1ps
module prog_model #(
  parameter int GAP_NS = 400
) (
  input  wire logic link_sdo_i,
  output logic      link_sck_o,
  output logic      link_sdi_o
);
  import flash_seq_pkg::*;
  logic [47:0] rx_bits;
  initial begin
    link_sck_o = 1'b0;
    link_sdi_o = 1'b1;
    rx_bits    = '0;
  end
  // One byte, MSB first; the clock stands low outside transfers
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      link_sdi_o = b[i];
      #100;
      rx_bits    = {rx_bits[46:0], link_sdo_i};
      link_sck_o = 1'b1;
      #100;
      link_sck_o = 1'b0;
    end
  endtask
  // Command frame after the gap; LEN counts COM and data
  task automatic send_cmd(input logic [7:0] len, input logic [7:0] body [7],
                          input logic [7:0] etx);
    logic [7:0] sum;
    #(GAP_NS + 3); // Small offset keeps link edges off the sampling clock edge
    sum = 8'h00 - len;
    xfer(FRAME_SOH);
    xfer(len);
    for (int i = 0; i < 7 && i < int'(len); i++) begin
      xfer(body[i]);
      sum = sum - body[i];
    end
    xfer(sum);
    xfer(etx);
  endtask
  // Waits, then asks for status while busy; res 0 normal, 1 abnormal, 2 time-out
  task automatic poll(input int wait_ns, input int limit, output int res,
                      output logic [7:0] st);
    logic [7:0]  req [7];
    logic [39:0] w;
    logic        seen;
    res = 2;
    st  = 8'h00;
    req = '{CMD_STATUS, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    #wait_ns;
    for (int n = 0; n < limit && res == 2; n++) begin
      send_cmd(LEN_STATUS, req, FRAME_ETX);
      repeat (6) xfer(IDLE_BYTE);
      seen = 1'b0;
      // Reply alignment depends on link skew, so search the captured bits
      for (int k = 8; k >= 0; k--) begin
        w = rx_bits[k+:40];
        if (!seen && w[39:24] == 16'h0201 && w[7:0] == FRAME_ETX) begin
          seen = 1'b1;
          st   = w[23:16];
          if (8'(8'h01 + w[23:16] + w[15:8]) != 8'h00) res = 1;
          else if (st != ST_BUSY) res = (st == ST_ACK) ? 0 : 1;
        end
      end
    end
    // No answer but busy, or no frame, within the window stays a time-out
  endtask
endmodule

//--- tb/tb.sv
// Testbench: erase and clock set sequences against the programmer model
`timescale 1ns/1ps
module tb;
  import flash_seq_pkg::*;
  logic          mclk_i, sys_rst_i, link_sck_i, link_sdi_i, link_sdo_o;
  logic          chip_erase_lock_i, boot_rewrite_lock_i, block_erase_lock_i;
  logic          erase_done_i, erase_fail_i, erase_start_o, frequency_set_o;
  erase_req_type erase_req_o, last_req;
  logic [31:0]   frequency_data_o;
  logic [7:0]    first_status_byte_o, st;
  logic [7:0]    body [7];
  int            mismatches, cmp_count, starts, freq_sets, res;

  flash_erase_clock_set_sequencer u_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link_sck_i(link_sck_i),
    .link_sdi_i(link_sdi_i), .link_sdo_o(link_sdo_o),
    .chip_erase_lock_i(chip_erase_lock_i), .boot_rewrite_lock_i(boot_rewrite_lock_i),
    .block_erase_lock_i(block_erase_lock_i), .erase_req_o(erase_req_o),
    .erase_start_o(erase_start_o), .erase_done_i(erase_done_i),
    .erase_fail_i(erase_fail_i), .frequency_data_o(frequency_data_o),
    .frequency_set_o(frequency_set_o), .first_status_byte_o(first_status_byte_o));
  prog_model u_prog (
    .link_sdo_i(link_sdo_o), .link_sck_o(link_sck_i), .link_sdi_o(link_sdi_i));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Count one-cycle pulses on the falling edge, where registered outputs have settled
  always @(negedge mclk_i) begin
    if (erase_start_o === 1'b1) begin
      starts++;
      last_req = erase_req_o;
    end
    if (frequency_set_o === 1'b1) freq_sets++;
  end

  task automatic check(input logic [48:0] got, input logic [48:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Send one frame, then let the result land (sync plus one cycle)
  task automatic cmd(input logic [7:0] len, input logic [7:0] c, input logic [47:0] d,
                     input logic [7:0] etx);
    body[0] = c;
    for (int i = 1; i < 7; i++) body[i] = d[(6-i)*8 +: 8];
    u_prog.send_cmd(len, body, etx);
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic done_pulse(input logic fail);
    @(posedge mclk_i);
    erase_done_i <= 1'b1;
    erase_fail_i <= fail;
    @(posedge mclk_i);
    erase_done_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask

  task automatic t_osc();
    cmd(LEN_OSC_SET, CMD_OSC_SET, 48'h1234_5678_0000, FRAME_ETX);
    check(freq_sets, 1, "frequency pulses");
    check(frequency_data_o, 32'h1234_5678, "frequency data");
    u_prog.poll(400, 4, res, st);
    check(res, 0, "clock set result");
    $display("test osc done");
  endtask
  task automatic t_chip();
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i);
      chip_erase_lock_i   <= (i == 0);
      boot_rewrite_lock_i <= (i == 1);
      cmd(LEN_CHIP_ERS, CMD_CHIP_ERS, '0, FRAME_ETX);
      check(first_status_byte_o, ST_PROTECT, "locked chip erase");
    end
    u_prog.poll(400, 2, res, st);
    check(res, 1, "protect classed abnormal");
    @(posedge mclk_i);
    boot_rewrite_lock_i <= 1'b0;
    check(starts, 0, "no job while locked");
    cmd(LEN_CHIP_ERS, CMD_CHIP_ERS, '0, FRAME_ETX);
    check({starts, last_req.block}, {32'd1, 1'b0}, "chip job");
    check(last_req, {1'b0, 24'h000000, 24'hffffff}, "chip job range");
    u_prog.poll(400, 3, res, st);
    check({res, st}, {32'd2, ST_BUSY}, "busy until limit");
    done_pulse(1'b0);
    u_prog.poll(400, 3, res, st);
    check({res, st}, {32'd0, ST_ACK}, "chip erase done");
    $display("test chip done");
  endtask
  task automatic t_block();
    @(posedge mclk_i);
    block_erase_lock_i <= 1'b1;
    cmd(LEN_BLK_ERS, CMD_BLK_ERS, 48'h00_1000_00_3fff, FRAME_ETX);
    check(first_status_byte_o, ST_PROTECT, "locked block erase");
    block_erase_lock_i <= 1'b0;
    cmd(LEN_BLK_ERS, CMD_BLK_ERS, 48'h00_3fff_00_1000, FRAME_ETX);
    check(first_status_byte_o, ST_PARAM_ERR, "reversed block range");
    cmd(LEN_BLK_ERS, CMD_BLK_ERS, 48'h00_1000_00_3fff, FRAME_ETX);
    check(starts, 2, "block job count");
    check(last_req, {1'b1, 24'h001000, 24'h003fff}, "block job");
    done_pulse(1'b1);
    u_prog.poll(800, 3, res, st);
    check({res, st}, {32'd1, ST_MARGIN}, "erase failure");
    $display("test block done");
  endtask
  task automatic t_malformed();
    cmd(LEN_CHIP_ERS, CMD_CHIP_ERS, '0, 8'h00);
    check(first_status_byte_o, ST_NACK, "missing end byte");
    // Each bad frame follows an accepted one, so the status code has to change
    cmd(LEN_OSC_SET, CMD_OSC_SET, 48'h0a0b_0c0d_0000, FRAME_ETX);
    check(first_status_byte_o, ST_ACK, "clock set accepted");
    cmd(8'h02, CMD_CHIP_ERS, '0, FRAME_ETX);
    check(first_status_byte_o, ST_NACK, "wrong length");
    cmd(LEN_OSC_SET, CMD_OSC_SET, 48'h0a0b_0c0d_0000, FRAME_ETX);
    check(first_status_byte_o, ST_ACK, "clock set accepted again");
    cmd(8'h08, CMD_CHIP_ERS, '0, FRAME_ETX);
    check(first_status_byte_o, ST_NACK, "length field too large");
    check(freq_sets, 3, "frequency pulses after bad frames");
    check(starts, 2, "no job from bad frames");
    $display("test malformed done");
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Whole run needs well under half a millisecond
  initial begin
    #1_000_000;
    mismatches++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    {sys_rst_i, chip_erase_lock_i, boot_rewrite_lock_i} = 3'b100;
    {block_erase_lock_i, erase_done_i, erase_fail_i} = 3'b000;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check({link_sdo_o, first_status_byte_o}, {1'b1, ST1_RESET}, "reset state");
    t_osc();
    t_chip();
    t_block();
    t_malformed();
    complete_run();
  end
endmodule
